// ### rtl/intc_pkg.sv
// shared constants and types for the interrupt flag and enable registers
package intc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PORT_W = 8;
  localparam int EXT_LINES = 3;

  // register indices
  localparam logic [ADDR_W-1:0] IDX_MAIN = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_EDGE = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_EXT = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_PF1 = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_PF2 = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_PE1 = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_PE2 = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_PP1 = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_PP2 = 4'h8;
  localparam logic [ADDR_W-1:0] IDX_RSTCTL = 4'h9;
  localparam logic [ADDR_W-1:0] IDX_PORT = 4'ha;

  // reset values
  localparam logic [DATA_W-1:0] RST_MAIN = 8'h00;
  localparam logic [DATA_W-1:0] RST_EDGE = 8'hf5;
  localparam logic [DATA_W-1:0] RST_EXT = 8'hc0;
  localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] RST_PRIO1 = 8'h7f;
  localparam logic [DATA_W-1:0] RST_PRIO2 = 8'h95;

  // implemented bits, then the watched port pins
  localparam logic [DATA_W-1:0] MASK_EDGE = 8'hf5;
  localparam logic [DATA_W-1:0] MASK_EXT = 8'hdb;
  localparam logic [DATA_W-1:0] MASK_P1 = 8'h7f;
  localparam logic [DATA_W-1:0] MASK_PF1_WR = 8'h4f;
  localparam logic [DATA_W-1:0] MASK_P2 = 8'h95;
  localparam logic [DATA_W-1:0] MASK_RSTCTL = 8'h80;
  localparam logic [PORT_W-1:0] WATCH_MASK = 8'hf0;

  // main control fields
  localparam int B_GLOBAL_HIGH = 7;
  localparam int B_PERIPH_LOW = 6;
  localparam int B_T0_EN = 5;
  localparam int B_X0_EN = 4;
  localparam int B_PC_EN = 3;
  localparam int B_T0_FLAG = 2;
  localparam int B_X0_FLAG = 1;
  localparam int B_PC_FLAG = 0;
  // edge and priority fields
  localparam int B_PULLUP_DIS = 7;
  localparam int B_EDGE0 = 6;
  localparam int B_EDGE1 = 5;
  localparam int B_EDGE2 = 4;
  localparam int B_T0_PRIO = 2;
  localparam int B_PC_PRIO = 0;
  // external line fields
  localparam int B_X2_PRIO = 7;
  localparam int B_X1_PRIO = 6;
  localparam int B_X2_EN = 4;
  localparam int B_X1_EN = 3;
  localparam int B_X2_FLAG = 1;
  localparam int B_X1_FLAG = 0;
  // peripheral register one fields
  localparam int B_CONV = 6;
  localparam int B_RX = 5;
  localparam int B_TX = 4;
  localparam int B_SYNC = 3;
  localparam int B_CC1 = 2;
  localparam int B_T2 = 1;
  localparam int B_T1 = 0;
  // peripheral register two fields, then the reset control field
  localparam int B_OSC = 7;
  localparam int B_NV = 4;
  localparam int B_LV = 2;
  localparam int B_CC2 = 0;
  localparam int B_PRIO_MODE = 7;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic timer0_overflow;
    logic conversion_done;
    logic sync_serial_done;
    logic capcomp_one;
    logic timer2_match;
    logic timer1_overflow;
    logic osc_fail;
    logic nv_write_done;
    logic low_voltage;
    logic capcomp_two;
  } events_t;
endpackage

// ### rtl/pin_filter.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_filter #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pins;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit moves only once the last two stages agree
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level <= '0;
    end else begin
      level <= (stage2 & stage3) | (level & (stage2 | stage3));
    end
  end
endmodule // pin_filter

// ### rtl/interrupt_flag_enable_regs.sv
// interrupt enable, flag and priority registers with request gating
`timescale 1ns/10ps
module interrupt_flag_enable_regs (
  input wire logic clock,
  input wire logic rst,
  input wire intc_pkg::bus_req_t bus,
  output logic [intc_pkg::DATA_W-1:0] rdata,
  input wire intc_pkg::events_t events,
  input wire logic serial_rx_full,
  input wire logic serial_tx_empty,
  input wire logic [intc_pkg::EXT_LINES-1:0] ext_line_pins,
  input wire logic [intc_pkg::PORT_W-1:0] port_b_pins,
  input wire logic [intc_pkg::PORT_W-1:0] port_latch,
  output logic [intc_pkg::PORT_W-1:0] pullup_on,
  output logic high_request,
  output logic low_request
);
  logic [intc_pkg::DATA_W-1:0] ctl_main;
  logic [intc_pkg::DATA_W-1:0] ctl_edge;
  logic [intc_pkg::DATA_W-1:0] ctl_ext;
  logic [intc_pkg::DATA_W-1:0] pflags1;
  logic [intc_pkg::DATA_W-1:0] pflags2;
  logic [intc_pkg::DATA_W-1:0] penable1;
  logic [intc_pkg::DATA_W-1:0] penable2;
  logic [intc_pkg::DATA_W-1:0] pprio1;
  logic [intc_pkg::DATA_W-1:0] pprio2;
  logic [intc_pkg::DATA_W-1:0] rst_ctl;
  logic [intc_pkg::DATA_W-1:0] pf1_view;
  logic [intc_pkg::EXT_LINES-1:0] line_level;
  logic [intc_pkg::EXT_LINES-1:0] line_prev;
  logic [intc_pkg::EXT_LINES-1:0] line_fire;
  logic [intc_pkg::EXT_LINES-1:0] edge_sel;
  logic [intc_pkg::PORT_W-1:0] port_b_input;
  logic [intc_pkg::PORT_W-1:0] port_snapshot;
  logic port_mismatch;
  logic priority_mode_enable;
  logic global_high_enable;
  logic peripheral_low_enable;
  logic pullup_disable;
  logic [intc_pkg::DATA_W-1:0] set_main;
  logic [intc_pkg::DATA_W-1:0] set_ext;
  logic [intc_pkg::DATA_W-1:0] set_pf1;
  logic [intc_pkg::DATA_W-1:0] set_pf2;
  logic [intc_pkg::DATA_W-1:0] core_pend;
  logic [intc_pkg::DATA_W-1:0] core_prio;
  logic [intc_pkg::DATA_W-1:0] ext_pend;
  logic [intc_pkg::DATA_W-1:0] ext_prio;
  logic [intc_pkg::DATA_W-1:0] per_pend1;
  logic [intc_pkg::DATA_W-1:0] per_pend2;

  // stored value after an optional write, with hardware sets on top
  function automatic logic [intc_pkg::DATA_W-1:0] update(
    input logic [intc_pkg::DATA_W-1:0] cur,
    input logic hit,
    input logic [intc_pkg::DATA_W-1:0] wdata,
    input logic [intc_pkg::DATA_W-1:0] mask,
    input logic [intc_pkg::DATA_W-1:0] set
  );
    logic [intc_pkg::DATA_W-1:0] base;
    base = hit ? (wdata & mask) : cur;
    return (base | set) & mask;
  endfunction

  function automatic logic write_hit(input intc_pkg::bus_req_t b, input logic [intc_pkg::ADDR_W-1:0] idx);
    return b.wr && (b.addr == idx);
  endfunction

  // pending sources of one priority class
  function automatic logic any_pending(
    input logic [intc_pkg::DATA_W-1:0] pend,
    input logic [intc_pkg::DATA_W-1:0] prio,
    input logic want_high
  );
    return |(pend & (want_high ? prio : ~prio));
  endfunction

  pin_filter #(.WIDTH(intc_pkg::EXT_LINES)) line_filter (
    .clock(clock),
    .rst(rst),
    .pins(ext_line_pins),
    .level(line_level)
  );

  pin_filter #(.WIDTH(intc_pkg::PORT_W)) port_filter (
    .clock(clock),
    .rst(rst),
    .pins(port_b_pins),
    .level(port_b_input)
  );

  assign priority_mode_enable = rst_ctl[intc_pkg::B_PRIO_MODE];
  assign global_high_enable = ctl_main[intc_pkg::B_GLOBAL_HIGH];
  assign peripheral_low_enable = ctl_main[intc_pkg::B_PERIPH_LOW];
  assign pullup_disable = ctl_edge[intc_pkg::B_PULLUP_DIS];

  assign edge_sel = {ctl_edge[intc_pkg::B_EDGE2], ctl_edge[intc_pkg::B_EDGE1], ctl_edge[intc_pkg::B_EDGE0]};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      line_prev <= '0;
    end else begin
      line_prev <= line_level;
    end
  end

  assign line_fire = (edge_sel & line_level & ~line_prev) | (~edge_sel & ~line_level & line_prev);

  // port read takes a snapshot that ends the mismatch
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      port_snapshot <= '0;
    end else if (bus.rd && bus.addr == intc_pkg::IDX_PORT) begin
      port_snapshot <= port_b_input;
    end
  end

  // only the upper four pins are watched
  assign port_mismatch = |((port_b_input ^ port_snapshot) & intc_pkg::WATCH_MASK);

  // pull-ups follow the latch unless globally disabled
  assign pullup_on = pullup_disable ? '0 : port_latch;

  always_comb begin
    set_main = '0;
    set_ext = '0;
    set_pf1 = '0;
    set_pf2 = '0;
    set_main[intc_pkg::B_T0_FLAG] = events.timer0_overflow;
    set_main[intc_pkg::B_X0_FLAG] = line_fire[0];
    set_main[intc_pkg::B_PC_FLAG] = port_mismatch;
    set_ext[intc_pkg::B_X1_FLAG] = line_fire[1];
    set_ext[intc_pkg::B_X2_FLAG] = line_fire[2];
    set_pf1[intc_pkg::B_CONV] = events.conversion_done;
    set_pf1[intc_pkg::B_SYNC] = events.sync_serial_done;
    set_pf1[intc_pkg::B_CC1] = events.capcomp_one;
    set_pf2[intc_pkg::B_CC2] = events.capcomp_two;
    set_pf1[intc_pkg::B_T2] = events.timer2_match;
    set_pf1[intc_pkg::B_T1] = events.timer1_overflow;
    set_pf2[intc_pkg::B_OSC] = events.osc_fail;
    set_pf2[intc_pkg::B_NV] = events.nv_write_done;
    set_pf2[intc_pkg::B_LV] = events.low_voltage;
  end

  // main control with enables and sticky flags
  // set wins over a clearing write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl_main <= intc_pkg::RST_MAIN;
    end else begin
      ctl_main <= update(ctl_main, write_hit(bus, intc_pkg::IDX_MAIN), bus.wdata, '1, set_main);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl_edge <= intc_pkg::RST_EDGE;
    end else begin
      ctl_edge <= update(ctl_edge, write_hit(bus, intc_pkg::IDX_EDGE), bus.wdata, intc_pkg::MASK_EDGE, '0);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl_ext <= intc_pkg::RST_EXT;
    end else begin
      ctl_ext <= update(ctl_ext, write_hit(bus, intc_pkg::IDX_EXT), bus.wdata, intc_pkg::MASK_EXT, set_ext);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pflags1 <= intc_pkg::RST_ZERO;
      pflags2 <= intc_pkg::RST_ZERO;
    end else begin
      pflags1 <= update(pflags1, write_hit(bus, intc_pkg::IDX_PF1), bus.wdata, intc_pkg::MASK_PF1_WR, set_pf1);
      pflags2 <= update(pflags2, write_hit(bus, intc_pkg::IDX_PF2), bus.wdata, intc_pkg::MASK_P2, set_pf2);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      penable1 <= intc_pkg::RST_ZERO;
      penable2 <= intc_pkg::RST_ZERO;
      pprio1 <= intc_pkg::RST_PRIO1;
      pprio2 <= intc_pkg::RST_PRIO2;
    end else begin
      penable1 <= update(penable1, write_hit(bus, intc_pkg::IDX_PE1), bus.wdata, intc_pkg::MASK_P1, '0);
      penable2 <= update(penable2, write_hit(bus, intc_pkg::IDX_PE2), bus.wdata, intc_pkg::MASK_P2, '0);
      pprio1 <= update(pprio1, write_hit(bus, intc_pkg::IDX_PP1), bus.wdata, intc_pkg::MASK_P1, '0);
      pprio2 <= update(pprio2, write_hit(bus, intc_pkg::IDX_PP2), bus.wdata, intc_pkg::MASK_P2, '0);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rst_ctl <= intc_pkg::RST_ZERO;
    end else begin
      rst_ctl <= update(rst_ctl, write_hit(bus, intc_pkg::IDX_RSTCTL), bus.wdata, intc_pkg::MASK_RSTCTL, '0);
    end
  end

  always_comb begin
    pf1_view = pflags1;
    pf1_view[intc_pkg::B_RX] = serial_rx_full;
    pf1_view[intc_pkg::B_TX] = serial_tx_empty;
  end

  // read data only in the cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        intc_pkg::IDX_MAIN: rdata <= ctl_main;
        intc_pkg::IDX_EDGE: rdata <= ctl_edge;
        intc_pkg::IDX_EXT: rdata <= ctl_ext;
        intc_pkg::IDX_PF1: rdata <= pf1_view;
        intc_pkg::IDX_PF2: rdata <= pflags2;
        intc_pkg::IDX_PE1: rdata <= penable1;
        intc_pkg::IDX_PE2: rdata <= penable2;
        intc_pkg::IDX_PP1: rdata <= pprio1;
        intc_pkg::IDX_PP2: rdata <= pprio2;
        intc_pkg::IDX_RSTCTL: rdata <= rst_ctl;
        intc_pkg::IDX_PORT: rdata <= port_b_input;
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  always_comb begin
    core_pend = '0;
    core_prio = '0;
    core_pend[intc_pkg::B_T0_FLAG] = ctl_main[intc_pkg::B_T0_FLAG] & ctl_main[intc_pkg::B_T0_EN];
    core_pend[intc_pkg::B_X0_FLAG] = ctl_main[intc_pkg::B_X0_FLAG] & ctl_main[intc_pkg::B_X0_EN];
    core_pend[intc_pkg::B_PC_FLAG] = ctl_main[intc_pkg::B_PC_FLAG] & ctl_main[intc_pkg::B_PC_EN];
    core_prio[intc_pkg::B_T0_FLAG] = ctl_edge[intc_pkg::B_T0_PRIO];
    // line0 has no priority bit and is always high
    core_prio[intc_pkg::B_X0_FLAG] = 1'b1;
    core_prio[intc_pkg::B_PC_FLAG] = ctl_edge[intc_pkg::B_PC_PRIO];
    ext_pend = '0;
    ext_prio = '0;
    ext_pend[intc_pkg::B_X1_FLAG] = ctl_ext[intc_pkg::B_X1_FLAG] & ctl_ext[intc_pkg::B_X1_EN];
    ext_pend[intc_pkg::B_X2_FLAG] = ctl_ext[intc_pkg::B_X2_FLAG] & ctl_ext[intc_pkg::B_X2_EN];
    ext_prio[intc_pkg::B_X1_FLAG] = ctl_ext[intc_pkg::B_X1_PRIO];
    ext_prio[intc_pkg::B_X2_FLAG] = ctl_ext[intc_pkg::B_X2_PRIO];
    per_pend1 = pf1_view & penable1;
    per_pend2 = pflags2 & penable2;
  end

  // high class gated by the top enable
  // bit 6 gates peripherals or low class
  always_comb begin
    if (priority_mode_enable) begin
      high_request = global_high_enable & (any_pending(core_pend, core_prio, 1'b1)
        | any_pending(ext_pend, ext_prio, 1'b1) | any_pending(per_pend1, pprio1, 1'b1)
        | any_pending(per_pend2, pprio2, 1'b1));
      low_request = peripheral_low_enable & (any_pending(core_pend, core_prio, 1'b0)
        | any_pending(ext_pend, ext_prio, 1'b0) | any_pending(per_pend1, pprio1, 1'b0)
        | any_pending(per_pend2, pprio2, 1'b0));
    end else begin
      high_request = global_high_enable & ((|core_pend) | (|ext_pend)
        | (peripheral_low_enable & ((|per_pend1) | (|per_pend2))));
      low_request = 1'b0;
    end
  end

  sequence s_main_write;
    bus.wr && bus.addr == intc_pkg::IDX_MAIN;
  endsequence

  sequence s_port_read;
    bus.rd && bus.addr == intc_pkg::IDX_PORT;
  endsequence

  a_set_beats_clear: assert property (@(posedge clock) disable iff (rst)
    s_main_write ##0 events.timer0_overflow |=> ctl_main[intc_pkg::B_T0_FLAG])
    else $error("timer0 event lost to a clearing write");

  a_flag_sticky: assert property (@(posedge clock) disable iff (rst)
    ctl_main[intc_pkg::B_X0_FLAG] && !(bus.wr && bus.addr == intc_pkg::IDX_MAIN)
    |=> ctl_main[intc_pkg::B_X0_FLAG])
    else $error("line0 flag dropped without software clear");

  a_high_gate: assert property (@(posedge clock) disable iff (rst)
    priority_mode_enable && !global_high_enable |-> !high_request)
    else $error("high request with top enable clear");

  a_compat_low: assert property (@(posedge clock) disable iff (rst)
    !priority_mode_enable |-> !low_request)
    else $error("low request in compatibility mode");

  a_low_gate: assert property (@(posedge clock) disable iff (rst)
    priority_mode_enable && !peripheral_low_enable |-> !low_request)
    else $error("low request with bit 6 clear");

  a_timer0_request: assert property (@(posedge clock) disable iff (rst)
    !priority_mode_enable && global_high_enable && ctl_main[intc_pkg::B_T0_EN]
    && ctl_main[intc_pkg::B_T0_FLAG] |-> high_request)
    else $error("enabled timer0 flag gave no request");

  a_rx_mirror: assert property (@(posedge clock) disable iff (rst)
    bus.rd && bus.addr == intc_pkg::IDX_PF1 |=> rdata[intc_pkg::B_RX] == $past(serial_rx_full))
    else $error("receive flag does not follow buffer state");

  a_unimpl_zero: assert property (@(posedge clock) disable iff (rst)
    bus.rd && bus.addr == intc_pkg::IDX_EDGE |=> (rdata & ~intc_pkg::MASK_EDGE) == '0)
    else $error("unimplemented bits read nonzero");

  a_mismatch_sets: assert property (@(posedge clock) disable iff (rst)
    port_mismatch |=> ctl_main[intc_pkg::B_PC_FLAG])
    else $error("port mismatch did not set change flag");

  a_port_read_ends: assert property (@(posedge clock) disable iff (rst)
    s_port_read ##1 $stable(port_b_input) |-> !port_mismatch)
    else $error("port read did not end mismatch");

  a_pullup_off: assert property (@(posedge clock) disable iff (rst)
    pullup_disable |-> pullup_on == '0)
    else $error("pull-ups on while disabled");

  a_edge_rise: assert property (@(posedge clock) disable iff (rst)
    edge_sel[2] && line_level[2] && !line_prev[2] |=> ctl_ext[intc_pkg::B_X2_FLAG])
    else $error("rising edge on line2 missed");

  a_conv_flag: assert property (@(posedge clock) disable iff (rst)
    events.conversion_done |=> pflags1[intc_pkg::B_CONV])
    else $error("conversion flag not set");
endmodule // interrupt_flag_enable_regs

// ### bench/event_source.sv
// far-side model: peripheral event sources firing one-cycle pulses
`timescale 1ns/10ps
module event_source (
  input wire logic clock,
  input wire logic rst,
  input wire logic fire,
  input wire logic [3:0] which,
  output intc_pkg::events_t events
);
  // pulse launched by the edge that sees fire, gone one edge later
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      events <= '0;
    end else begin
      events <= fire ? intc_pkg::events_t'(10'h001 << which) : '0;
    end
  end
endmodule // event_source

// ### bench/interrupt_flag_enable_regs_bench.sv
// self-checking bench for the interrupt flag and enable registers
`timescale 1ns/10ps
module interrupt_flag_enable_regs_bench;
  logic clock, rst, fire, rx_full, tx_empty, high_req, low_req;
  logic [3:0] which;
  logic [2:0] ext_pins;
  logic [7:0] port_pins, latch, pullup_on, rdata;
  logic [31:0] r;
  intc_pkg::bus_req_t bus;
  intc_pkg::events_t events;
  int mismatches, num_checks, cycles, seed;
  localparam logic [7:0] RST_V [10] = '{intc_pkg::RST_MAIN, intc_pkg::RST_EDGE, intc_pkg::RST_EXT, 8'h00,
    8'h00, 8'h00, 8'h00, intc_pkg::RST_PRIO1, intc_pkg::RST_PRIO2, 8'h00};
  localparam logic [3:0] EV_REG [10] = '{4'h4, 4'h4, 4'h4, 4'h4, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h0};
  localparam int EV_BIT [10] = '{0, 2, 4, 7, 0, 1, 2, 3, 6, 2};
  // address, data, then expected high and low request
  localparam logic [15:0] REQ_STEPS [14] = '{16'h0240, 16'h0a42, 16'h1802, 16'h9800, 16'h0e41, 16'h1842,
    16'h0640, 16'h9000, 16'h0000, 16'h5400, 16'h3400, 16'h0800, 16'h0c02, 16'h3000};

  interrupt_flag_enable_regs interrupt_flag_enable_regs_i (.clock(clock), .rst(rst), .bus(bus),
    .rdata(rdata), .events(events), .serial_rx_full(rx_full), .serial_tx_empty(tx_empty),
    .ext_line_pins(ext_pins), .port_b_pins(port_pins), .port_latch(latch), .pullup_on(pullup_on),
    .high_request(high_req), .low_request(low_req));
  event_source event_source_i (.clock(clock), .rst(rst), .fire(fire), .which(which), .events(events));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  function automatic logic [7:0] expect_rd(input logic [3:0] a, input logic [7:0] d);
    case (a)
      4'h0: return d;
      4'h1: return d & intc_pkg::MASK_EDGE;
      4'h2: return d & intc_pkg::MASK_EXT;
      4'h3: return (d & intc_pkg::MASK_PF1_WR) | {2'b00, rx_full, tx_empty, 4'h0};
      4'h4, 4'h6, 4'h8: return d & intc_pkg::MASK_P2;
      4'h5, 4'h7: return d & intc_pkg::MASK_P1;
      4'h9: return d & intc_pkg::MASK_RSTCTL;
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '0;
    #1;
  endtask

  task automatic rc(input logic [3:0] a, input logic [7:0] exp, input bit ck = 1'b1);
    @(posedge clock);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '0;
    #1;
    if (ck) chk(rdata, exp);
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    seed = 23347;
    rst = 1'b1;
    fire = 1'b0;
    which = 4'h0;
    rx_full = 1'b0;
    tx_empty = 1'b0;
    ext_pins = 3'b000;
    port_pins = 8'h00;
    latch = 8'h00;
    bus = '0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      if (a != 10) rc(a[3:0], expect_rd(a[3:0], a < 10 ? RST_V[a] : 8'h00));
    end
    chk(pullup_on, 8'h00);
    $display("reset values done");
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      if (r[3:0] == 4'ha) r[3:0] = 4'h9;
      @(posedge clock);
      rx_full <= r[12];
      tx_empty <= r[13];
      latch <= r[31:24];
      wr(r[3:0], r[23:16]);
      rc(r[3:0], expect_rd(r[3:0], r[23:16]));
    end
    for (int a = 0; a < 10; a++) wr(a[3:0], 8'h00);
    chk(pullup_on, latch);
    wr(4'h1, 8'h80);
    chk(pullup_on, 8'h00);
    $display("register access done");
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      fire <= 1'b1;
      which <= i[3:0];
      @(posedge clock);
      fire <= 1'b0;
      repeat (2) @(posedge clock);
      rc(EV_REG[i], expect_rd(EV_REG[i], 8'h01 << EV_BIT[i]));
      wr(EV_REG[i], 8'h00);
      rc(EV_REG[i], expect_rd(EV_REG[i], 8'h00));
    end
    // event lands on the same edge as the clearing write
    fork
      wr(4'h0, 8'h00);
      begin
        fire <= 1'b1;
        which <= 4'h9;
        @(posedge clock);
        fire <= 1'b0;
      end
    join
    rc(4'h0, 8'h04);
    $display("event flags done");
    foreach (REQ_STEPS[i]) begin
      wr(REQ_STEPS[i][15:12], REQ_STEPS[i][11:4]);
      chk({6'h00, high_req, low_req}, {4'h0, REQ_STEPS[i][3:0]});
    end
    wr(4'h5, 8'h00);
    $display("requests done");
    // line0 and line2 rising, line1 falling
    wr(4'h1, 8'h50);
    @(posedge clock);
    ext_pins <= 3'b111;
    repeat (8) @(posedge clock);
    rc(4'h0, 8'hc2);
    rc(4'h2, 8'h02);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h00);
    @(posedge clock);
    ext_pins <= 3'b000;
    repeat (8) @(posedge clock);
    rc(4'h0, 8'h00);
    rc(4'h2, 8'h01);
    wr(4'h2, 8'h00);
    $display("external lines done");
    @(posedge clock);
    port_pins <= 8'h01;
    repeat (8) @(posedge clock);
    rc(4'h0, 8'h00);
    @(posedge clock);
    port_pins <= 8'h81;
    repeat (8) @(posedge clock);
    rc(4'h0, 8'h01);
    wr(4'h0, 8'h00);
    rc(4'h0, 8'h01);
    rc(4'ha, 8'h81);
    wr(4'h0, 8'h00);
    rc(4'h0, 8'h00);
    $display("port change done");
    wrap_up();
  end
endmodule // interrupt_flag_enable_regs_bench
